// File: imu_filter_settling.v
// imu_filter_settling.v: filter configuration and settling tracking for
// accel and gyro sample streams, registers over axi4-lite
// assumes sample strobes at the output rate, synchronous to sys_clk_i
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "imu_filter_regs.vh"

// What this block does
// R1 - accel settling follows mode and rate normally
// R2 - new accel config applies at period end
// R3 - reader drops extra sample; rate change three
// R4 - reader drops rate dependent sample count
// R5 - narrow cutoff uses composite filter counts
// R6 - reader drops up to cutoff table counts
// R7 - gyro chain highpass, first, second lowpass
// R8 - gyro highpass only high performance, 2-bit cutoff
// R9 - highpass cutoff code picks settling seconds
// R10 - first lowpass select bit, 3-bit type
// R11 - second lowpass follows only gyro rate
// R12 - type codes 1xx refused at fastest rates
// R13 - samples marked unsettled until count elapses
module imu_filter_settling (
    input wire sys_clk_i,
    input wire reset_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire accel_sample_i,
    input wire gyro_sample_i,
    output reg accel_settled_o,
    output reg gyro_settled_o,
    output reg [3:0] gyro_stage_en_o,
    output reg [2:0] gyro_lowpass_type_o,
    output reg [1:0] gyro_highpass_cutoff_sel_o,
    output reg [3:0] gyro_rate_o
);
    parameter integer HP_SETTLE_SCALE = 1;

    reg [15:0] accel_shadow;
    reg [15:0] accel_active;
    reg accel_pending;
    reg [5:0] gyro_ctrl;
    reg [7:0] common_control_four;
    reg [7:0] common_control_six;
    reg [7:0] gyro_control_seven;
    reg [7:0] aw_addr;
    reg aw_have;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_have;
    reg [15:0] accel_load_val;
    reg accel_load;
    reg [15:0] gyro_load_val;
    reg gyro_load;
    reg gyro_load_d;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    reg [15:0] next_accel_count;
    reg [15:0] rate_count;
    reg [15:0] next_gyro_count;
    reg [31:0] hp_ds;
    reg [31:0] hp_samples;
    wire [15:0] accel_left;
    wire [15:0] gyro_left;
    wire accel_done;
    wire gyro_done;

    wire [3:0] acc_rate = accel_active[`ACC_RATE_MSB:`ACC_RATE_LSB];
    wire [1:0] acc_mode = accel_active[`ACC_MODE_MSB:`ACC_MODE_LSB];
    wire [3:0] new_rate = accel_shadow[`ACC_RATE_MSB:`ACC_RATE_LSB];
    wire [1:0] new_mode = accel_shadow[`ACC_MODE_MSB:`ACC_MODE_LSB];
    wire new_lp2 = accel_shadow[`ACC_LP2_BIT];
    wire new_hppath = accel_shadow[`ACC_HPPATH_BIT];
    wire [2:0] new_cut = accel_shadow[`ACC_CUT_MSB:`ACC_CUT_LSB];
    wire [3:0] g_rate = gyro_ctrl[`GYR_RATE_MSB:`GYR_RATE_LSB];
    wire [1:0] g_mode = gyro_ctrl[`GYR_MODE_MSB:`GYR_MODE_LSB];
    wire [2:0] lp_type = common_control_six[`LP_TYPE_MSB:`LP_TYPE_LSB];
    wire fast_rate = (g_rate == `RATE_3333) || (g_rate == `RATE_6667);
    wire wr_go = aw_have && w_have && !s_axi_bvalid;

    // per-rate discard for a target configuration
    always @* begin
        rate_count = `ACC_HP_LOW;
        if (new_mode == `MODE_LP) begin
            rate_count = `ACC_LP_FROM_PD;  // [R4]
        end else if (new_rate == `RATE_1667) begin
            rate_count = `ACC_HP_1667;  // [R4]
        end else if (new_rate == `RATE_3333) begin
            rate_count = `ACC_HP_3333;  // [R4]
        end else if (new_rate == `RATE_6667) begin
            rate_count = `ACC_HP_6667;  // [R4]
        end
    end

    // accel discard count for the pending configuration
    always @* begin
        next_accel_count = rate_count;  // [R1]
        if ((new_lp2 || new_hppath) && new_cut != `CUT_ODR4) begin
            case (new_cut)  // [R5] [R6]
                3'h1: next_accel_count = new_hppath ? `ACC_CUT1_HPF : `ACC_CUT1;
                3'h2: next_accel_count = `ACC_CUT2;
                3'h3: next_accel_count = `ACC_CUT3;
                3'h4: next_accel_count = `ACC_CUT4;
                3'h5: next_accel_count = `ACC_CUT5;
                3'h6: next_accel_count = `ACC_CUT6;
                default: next_accel_count = `ACC_CUT7;
            endcase
        end else if (new_mode == `MODE_PD) begin
            next_accel_count = 16'h0000;
        end else if (acc_mode == `MODE_HP && new_mode == `MODE_HP && acc_rate != new_rate) begin
            if (rate_count < `ACC_HP_RATE_CHG) begin
                next_accel_count = `ACC_HP_RATE_CHG;  // [R3]
            end
        end else if (acc_mode != new_mode && acc_mode != `MODE_PD) begin
            next_accel_count = rate_count + `ACC_MODE_SWITCH_EXTRA;  // [R3]
        end
    end

    // gyro discard: base count, or highpass settling tenths divided down to whole seconds when highpass is on
    always @* begin
        case (gyro_control_seven[`HP_CUT_MSB:`HP_CUT_LSB])  // [R9]
            2'h0: hp_ds = `HP_SETTLE_DS0;
            2'h1: hp_ds = `HP_SETTLE_DS1;
            2'h2: hp_ds = `HP_SETTLE_DS2;
            default: hp_ds = `HP_SETTLE_DS3;
        endcase
        hp_samples = hp_ds / (`DS_PER_S * HP_SETTLE_SCALE);
        next_gyro_count = `GYR_BASE_DISCARD;
        if (gyro_control_seven[`HP_EN_BIT] && g_mode == `MODE_HP) begin
            next_gyro_count = hp_samples[15:0];  // [R8]
        end
    end

    // register writes and read mux
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `RESP_OKAY;
        if (s_axi_araddr == `OFS_ACCEL_CTRL) begin
            next_rdata = {16'h0000, accel_shadow};
        end else if (s_axi_araddr == `OFS_GYRO_CTRL) begin
            next_rdata = {26'h0000000, gyro_ctrl};
        end else if (s_axi_araddr == `OFS_common_control_four) begin
            next_rdata = {24'h000000, common_control_four};
        end else if (s_axi_araddr == `OFS_common_control_six) begin
            next_rdata = {24'h000000, common_control_six};
        end else if (s_axi_araddr == `OFS_gyro_control_seven) begin
            next_rdata = {24'h000000, gyro_control_seven};
        end else if (s_axi_araddr == `OFS_STATUS) begin
            next_rdata = {29'h00000000, accel_pending, gyro_done, accel_done};
        end else if (s_axi_araddr == `OFS_ACCEL_LEFT) begin
            next_rdata = {16'h0000, accel_left};
        end else if (s_axi_araddr == `OFS_GYRO_LEFT) begin
            next_rdata = {16'h0000, gyro_left};
        end else begin
            next_rresp = `RESP_SLVERR;
        end
    end

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            accel_shadow <= 16'h0000;
            accel_active <= 16'h0000;
            accel_pending <= 1'b0;
            gyro_ctrl <= 6'h00;
            common_control_four <= 8'h00;
            common_control_six <= 8'h00;
            gyro_control_seven <= 8'h00;
            accel_load <= 1'b0;
            accel_load_val <= 16'h0000;
            gyro_load <= 1'b0;
            gyro_load_val <= 16'h0000;
            gyro_load_d <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            accel_load <= 1'b0;
            gyro_load <= 1'b0;
            if (wr_go) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                if (aw_addr == `OFS_ACCEL_CTRL) begin
                    if (w_strb[0]) accel_shadow[7:0] <= w_data[7:0];
                    if (w_strb[1]) accel_shadow[15:8] <= {5'h00, w_data[10:8]};
                    accel_pending <= 1'b1;  // [R2]
                end else if (aw_addr == `OFS_GYRO_CTRL) begin
                    if (w_strb[0]) gyro_ctrl <= w_data[5:0];
                    gyro_load <= 1'b1;  // [R13]
                end else if (aw_addr == `OFS_common_control_four) begin
                    if (w_strb[0]) common_control_four <= w_data[7:0];
                    gyro_load <= 1'b1;
                end else if (aw_addr == `OFS_common_control_six) begin
                    if (w_strb[0]) common_control_six <= w_data[7:0];
                    gyro_load <= 1'b1;
                end else if (aw_addr == `OFS_gyro_control_seven) begin
                    if (w_strb[0]) gyro_control_seven <= w_data[7:0];
                    gyro_load <= 1'b1;
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // accel config applied when the current period completes
            if (accel_pending && accel_sample_i) begin
                accel_active <= accel_shadow;  // [R2]
                accel_pending <= wr_go && (aw_addr == `OFS_ACCEL_CTRL);  // [R2]
                accel_load <= 1'b1;
                accel_load_val <= next_accel_count;  // [R13]
            end
            gyro_load_val <= next_gyro_count;
            gyro_load_d <= gyro_load;
        end
    end

    settle_counter accel_settle (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .load_i(accel_load),
        .count_i(accel_load_val),
        .sample_i(accel_sample_i),
        .left_o(accel_left),
        .settled_o(accel_done)
    );

    settle_counter gyro_settle (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .load_i(gyro_load_d),
        .count_i(gyro_load_val),
        .sample_i(gyro_sample_i),
        .left_o(gyro_left),
        .settled_o(gyro_done)
    );

    // gyro chain stage controls
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            accel_settled_o <= 1'b0;
            gyro_settled_o <= 1'b0;
            gyro_stage_en_o <= 4'h0;
            gyro_lowpass_type_o <= 3'h0;
            gyro_highpass_cutoff_sel_o <= 2'h0;
            gyro_rate_o <= 4'h0;
        end else begin
            accel_settled_o <= accel_done && !accel_pending && !accel_load;  // [R13]
            gyro_settled_o <= gyro_done && !gyro_load && !gyro_load_d;  // [R13]
            // stage order: highpass, first lowpass, second lowpass [R7]
            gyro_stage_en_o[0] <= gyro_control_seven[`HP_EN_BIT] && g_mode == `MODE_HP;  // [R8]
            gyro_stage_en_o[1] <= common_control_four[`FIRST_LP_BIT];  // [R10]
            gyro_stage_en_o[2] <= (g_rate != `RATE_OFF);  // [R11]
            gyro_stage_en_o[3] <= fast_rate && lp_type[2];  // [R12]
            gyro_lowpass_type_o <= (fast_rate && lp_type[2]) ? 3'h0 : lp_type;  // [R12]
            gyro_highpass_cutoff_sel_o <= gyro_control_seven[`HP_CUT_MSB:`HP_CUT_LSB];
            gyro_rate_o <= g_rate;  // [R11]
        end
    end
endmodule
`default_nettype wire

// File: imu_filter_regs.vh
// imu_filter_regs.vh: register offsets, fields, codes and discard counts
// assumes inclusion by the settling block and its bench; definitions only
`ifndef IMU_FILTER_REGS_VH
`define IMU_FILTER_REGS_VH

// register byte offsets on the axi4-lite slave
`define OFS_ACCEL_CTRL 8'h00
`define OFS_GYRO_CTRL 8'h04
`define OFS_common_control_four 8'h08
`define OFS_common_control_six 8'h0c
`define OFS_gyro_control_seven 8'h10
`define OFS_STATUS 8'h14
`define OFS_ACCEL_LEFT 8'h18
`define OFS_GYRO_LEFT 8'h1c

// accel control: [3:0] rate code, [5:4] mode, [6] second lowpass en,
// [7] highpass path select, [10:8] composite cutoff
`define ACC_RATE_LSB 0
`define ACC_RATE_MSB 3
`define ACC_MODE_LSB 4
`define ACC_MODE_MSB 5
`define ACC_LP2_BIT 6
`define ACC_HPPATH_BIT 7
`define ACC_CUT_LSB 8
`define ACC_CUT_MSB 10
// gyro control: [3:0] rate code, [5:4] mode
`define GYR_RATE_LSB 0
`define GYR_RATE_MSB 3
`define GYR_MODE_LSB 4
`define GYR_MODE_MSB 5
// common_control_four: [1] first lowpass select
`define FIRST_LP_BIT 1
// common_control_six: [2:0] lowpass type
`define LP_TYPE_LSB 0
`define LP_TYPE_MSB 2
// gyro_control_seven: [6] highpass enable, [5:4] cutoff sel
`define HP_EN_BIT 6
`define HP_CUT_LSB 4
`define HP_CUT_MSB 5

// power modes
`define MODE_PD 2'h0
`define MODE_LP 2'h1
`define MODE_HP 2'h2

// rate codes
`define RATE_OFF 4'h0
`define RATE_12 4'h1
`define RATE_26 4'h2
`define RATE_52 4'h3
`define RATE_104 4'h4
`define RATE_208 4'h5
`define RATE_416 4'h6
`define RATE_833 4'h7
`define RATE_1667 4'h8
`define RATE_3333 4'h9
`define RATE_6667 4'ha
`define RATE_1P6 4'hb

// accel discard counts
`define ACC_LP_FROM_PD 16'h0002
`define ACC_HP_LOW 16'h0003
`define ACC_HP_1667 16'h0003
`define ACC_HP_3333 16'h0005
`define ACC_HP_6667 16'h000b
`define ACC_HP_RATE_CHG 16'h0003
`define ACC_MODE_SWITCH_EXTRA 16'h0001
`define CUT_ODR4 3'h0
`define ACC_CUT1 16'h000a
`define ACC_CUT1_HPF 16'h000e
`define ACC_CUT2 16'h0013
`define ACC_CUT3 16'h0026
`define ACC_CUT4 16'h004b
`define ACC_CUT5 16'h0096
`define ACC_CUT6 16'h0128
`define ACC_CUT7 16'h0253

// gyro highpass settling in seconds, tenths
`define HP_SETTLE_DS0 32'd450
`define HP_SETTLE_DS1 32'd110
`define HP_SETTLE_DS2 32'd30
`define HP_SETTLE_DS3 32'd7
`define DS_PER_S 32'd10
`define GYR_BASE_DISCARD 16'h0003

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: settle_counter.v
// settle_counter.v: counts output samples down after a configuration change
// assumes a one-cycle sample strobe and a one-cycle load strobe
`timescale 1ns/1ps
`default_nettype none
module settle_counter (
    input wire sys_clk_i,
    input wire reset_i,
    input wire load_i,
    input wire [15:0] count_i,
    input wire sample_i,
    output reg [15:0] left_o,
    output reg settled_o
);
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            left_o <= 16'h0000;
            settled_o <= 1'b0;
        end else if (load_i) begin
            left_o <= count_i;
            settled_o <= (count_i == 16'h0000);
        end else if (sample_i && left_o != 16'h0000) begin
            left_o <= left_o - 16'h0001;
            settled_o <= (left_o == 16'h0001);
        end
    end
endmodule
`default_nettype wire

// File: imu_filter_settling_sva.sv
// imu_filter_settling_sva.sv: port checker for the settling block
// assumes one clock domain and the bind below onto imu_filter_settling
`timescale 1ns/1ps
`default_nettype none
module imu_filter_settling_sva (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic accel_sample_i,
    input wire logic accel_settled_o,
    input wire logic [3:0] gyro_stage_en_o,
    input wire logic [2:0] gyro_lowpass_type_o,
    input wire logic [3:0] gyro_rate_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire logic fast = (gyro_rate_o == 4'h9) || (gyro_rate_o == 4'ha);
    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_rd_bad;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h1c);
    endsequence
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_answer;
        s_aw_taken |-> ##[1:4] s_axi_bvalid;
    endproperty
    property p_rd_refuse;
        s_rd_bad |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    property p_refused;
        gyro_stage_en_o[3] |-> gyro_lowpass_type_o == 3'h0 && fast;
    endproperty
    property p_type_fast;
        gyro_lowpass_type_o[2] |-> !fast;
    endproperty
    property p_second_lp;
        gyro_stage_en_o[2] == (gyro_rate_o != 4'h0);
    endproperty
    property p_settle_tick;
        $rose(accel_settled_o) |->
            $past(accel_sample_i) || $past(accel_sample_i, 2) || $past(accel_sample_i, 3);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped before bready");
    a_rhold: assert property (p_rhold) else $error("read answer changed before rready");
    a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
    a_rd_refuse: assert property (p_rd_refuse) else $error("unmapped read not refused");
    a_refused: assert property (p_refused) else $error("refused type not cleared");
    a_type_fast: assert property (p_type_fast) else $error("1xx type at fast rate");
    a_second_lp: assert property (p_second_lp) else $error("second lowpass vs rate");
    a_settle_tick: assert property (p_settle_tick) else $error("settled off sample");
endmodule
bind imu_filter_settling imu_filter_settling_sva i_imu_filter_settling_sva (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .accel_sample_i(accel_sample_i),
    .accel_settled_o(accel_settled_o), .gyro_stage_en_o(gyro_stage_en_o),
    .gyro_lowpass_type_o(gyro_lowpass_type_o), .gyro_rate_o(gyro_rate_o));
`default_nettype wire

// File: tb_imu_filter_settling.sv
// tb_imu_filter_settling.sv: self-checking bench for the settling block
// assumes imu_filter_regs.vh on the include path and the checker bound
`timescale 1ns/1ps
`default_nettype none
`include "imu_filter_regs.vh"
module tb_imu_filter_settling;
    logic sys_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic accel_sample_i = 1'h0, gyro_sample_i = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, gyro_highpass_cutoff_sel_o;
    wire [31:0] s_axi_rdata;
    wire accel_settled_o, gyro_settled_o;
    wire [3:0] gyro_stage_en_o, gyro_rate_o;
    wire [2:0] gyro_lowpass_type_o;
    int mismatches = 0, n_compared = 0, cycles = 0;
    logic [15:0] cut[7] = '{16'h000a, 16'h0013, 16'h0026, 16'h004b, 16'h0096, 16'h0128, 16'h0253};
    logic [15:0] hp[4] = '{16'h002d, 16'h000b, 16'h0003, 16'h0000};
    always #2 sys_clk_i = ~sys_clk_i;
    imu_filter_settling i_imu_filter_settling (.sys_clk_i, .reset_i, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .accel_sample_i, .gyro_sample_i, .accel_settled_o, .gyro_settled_o, .gyro_stage_en_o,
        .gyro_lowpass_type_o, .gyro_highpass_cutoff_sel_o, .gyro_rate_o);
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er, "write response");
        s_axi_bready <= 1'h0;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic rdr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        chk(s_axi_rresp, er, "read response");
        chk(s_axi_rdata, ed, "read data");
        s_axi_rready <= 1'h0;
        @(posedge sys_clk_i);
    endtask
    task automatic pulse(input bit on_accel, input int n);
        repeat (n) begin
            if (on_accel) accel_sample_i <= 1'h1;
            else gyro_sample_i <= 1'h1;
            @(posedge sys_clk_i);
            accel_sample_i <= 1'h0;
            gyro_sample_i <= 1'h0;
            repeat (3) @(posedge sys_clk_i);
        end
    endtask
    // write accel control, apply at a sample, check count, optionally drain
    task automatic acc(input logic [31:0] d, input logic [15:0] n, input bit drain);
        wr(`OFS_ACCEL_CTRL, d, `RESP_OKAY);
        chk(accel_settled_o, 1'h0, "settled while pending");
        pulse(1, 1);
        rdr(`OFS_ACCEL_LEFT, `RESP_OKAY, {16'h0000, n});
        if (drain) begin
            if (n != 16'h0000) begin
                pulse(1, n - 1);
                chk(accel_settled_o, 1'h0, "settled one sample early");
                pulse(1, 1);
            end
            chk(accel_settled_o, 1'h1, "settled after count");
        end
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'h0;
        @(posedge sys_clk_i);
        chk(accel_settled_o, 1'h0, "accel settled at reset");
        chk(gyro_stage_en_o, 4'h0, "stages at reset");
        rdr(`OFS_ACCEL_CTRL, `RESP_OKAY, 32'h0);
        $display("test reset done");
        acc(32'h002a, 16'h000b, 1);
        acc(32'h0029, 16'h0005, 0);
        acc(32'h0027, 16'h0003, 0);
        acc(32'h0014, 16'h0003, 1);
        acc(32'h0025, 16'h0004, 0);
        acc(32'h0000, 16'h0000, 1);
        $display("test accel mode and rate done");
        rdr(`OFS_STATUS, `RESP_OKAY, 32'h1);
        foreach (cut[i]) acc(32'h0066 | ((i + 1) << 8), cut[i], 0);
        acc(32'h01a6, 16'h000e, 1);
        $display("test composite cutoff done");
        rdr(8'h20, `RESP_SLVERR, 32'h0);
        wr(`OFS_STATUS, 32'h7, `RESP_SLVERR);
        $display("test refusals done");
        wr(`OFS_GYRO_CTRL, 32'h0029, `RESP_OKAY);
        chk(gyro_rate_o, 4'h9, "gyro rate");
        chk(gyro_stage_en_o[2], 1'h1, "second lowpass on");
        rdr(`OFS_GYRO_LEFT, `RESP_OKAY, 32'h3);
        for (int t = 0; t < 8; t++) begin
            wr(`OFS_common_control_six, t, `RESP_OKAY);
            chk(gyro_lowpass_type_o, t[2] ? 3'h0 : t[2:0], "type at 3333");
            chk(gyro_stage_en_o[3], t[2], "type refused");
        end
        wr(`OFS_GYRO_CTRL, 32'h0021, `RESP_OKAY);
        chk(gyro_lowpass_type_o, 3'h7, "type at 12.5");
        wr(`OFS_common_control_four, 32'h2, `RESP_OKAY);
        chk(gyro_stage_en_o[1], 1'h1, "first lowpass");
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_gyro_control_seven, 32'h40 | (c << 4), `RESP_OKAY);
            chk(gyro_stage_en_o[0], 1'h1, "highpass on");
            chk(gyro_highpass_cutoff_sel_o, c[1:0], "highpass cutoff");
            rdr(`OFS_GYRO_LEFT, `RESP_OKAY, {16'h0000, hp[c]});
        end
        wr(`OFS_GYRO_CTRL, 32'h0019, `RESP_OKAY);
        chk(gyro_stage_en_o[0], 1'h0, "highpass off in low power");
        rdr(`OFS_GYRO_LEFT, `RESP_OKAY, 32'h3);
        pulse(0, 2);
        chk(gyro_settled_o, 1'h0, "gyro early");
        pulse(0, 1);
        chk(gyro_settled_o, 1'h1, "gyro settled");
        wr(`OFS_GYRO_CTRL, 32'h0000, `RESP_OKAY);
        chk(gyro_stage_en_o[2], 1'h0, "second lowpass off");
        chk(gyro_settled_o, 1'h0, "gyro unsettled after write");
        $display("test gyro chain done");
        complete_run();
    end
endmodule
`default_nettype wire
